//--- fcu_pkg.sv
package fcu_pkg;

  // Register indices; the byte address on the bus is four times the index
  localparam logic [11:0] FCU_CMD_IDX    = 12'hFF8;
  localparam logic [11:0] FCU_PAGE_IDX   = 12'hFF9;
  localparam logic [11:0] FCU_OPT_IDX    = 12'hFF0;
  localparam int          FCU_ADDR_W     = 14;
  localparam logic [13:0] FCU_CMD_ADDR   = {FCU_CMD_IDX, 2'b00};
  localparam logic [13:0] FCU_PAGE_ADDR  = {FCU_PAGE_IDX, 2'b00};
  localparam logic [13:0] FCU_OPT_ADDR   = {FCU_OPT_IDX, 2'b00};

  // Command codes
  localparam logic [7:0] FCU_CMD_UNLOCK1 = 8'h73;
  localparam logic [7:0] FCU_CMD_UNLOCK2 = 8'h8C;
  localparam logic [7:0] FCU_CMD_PERASE  = 8'h95;
  localparam logic [7:0] FCU_CMD_MERASE  = 8'h63;
  localparam logic [7:0] FCU_CMD_GUARD   = 8'h5E;

  // Status codes, upper two bits always zero
  localparam logic [5:0] FCU_ST_LOCKED   = 6'h00;
  localparam logic [5:0] FCU_ST_UNLK1    = 6'h01;
  localparam logic [5:0] FCU_ST_UNLK2    = 6'h02;
  localparam logic [5:0] FCU_ST_UNLOCKED = 6'h03;
  localparam logic [5:0] FCU_ST_GUARD    = 6'h04;
  localparam logic [5:0] FCU_ST_PROG     = 6'h08;
  localparam logic [5:0] FCU_ST_PERASE   = 6'h10;
  localparam logic [5:0] FCU_ST_MERASE   = 6'h20;

  // Page select layout
  localparam int FCU_INFO_BIT   = 7;
  localparam int FCU_PAGE_W     = 7;
  localparam int FCU_PAGE_LSB   = 9;
  localparam int FCU_SECT_LSB   = 2;
  localparam logic [6:0] FCU_INFO_PAGE = 7'h7F;

  // Option register layout
  localparam int FCU_OPT_WP_BIT = 0;
  localparam int FCU_OPT_RP_BIT = 1;

  // Reset values
  localparam logic [7:0] FCU_PAGE_RST  = 8'h00;
  localparam logic [7:0] FCU_GUARD_RST = 8'h00;
  localparam logic [1:0] FCU_OPT_RST   = 2'h0;

  // Operation times
  localparam int FCU_CLK_MHZ       = 200;
  localparam int FCU_PROG_TIME_US  = 40;
  localparam int FCU_PERASE_TIME_US = 10000;
  localparam int FCU_MERASE_TIME_US = 200000;
  localparam int FCU_PROG_CYC      = FCU_PROG_TIME_US * FCU_CLK_MHZ;
  localparam int FCU_PERASE_CYC    = FCU_PERASE_TIME_US * FCU_CLK_MHZ;
  localparam int FCU_MERASE_CYC    = FCU_MERASE_TIME_US * FCU_CLK_MHZ;
  localparam int FCU_TMR_W         = 26;

  typedef enum logic [2:0] {
    FCU_LOCKED   = 3'b000,
    FCU_UNLK1    = 3'b001,
    FCU_UNLK2    = 3'b010,
    FCU_UNLOCKED = 3'b011,
    FCU_GUARD    = 3'b100,
    FCU_PROG     = 3'b101,
    FCU_PERASE   = 3'b110,
    FCU_MERASE   = 3'b111
  } fcu_state_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  data;
    logic        debug;
  } fcu_prog_req_type;

  typedef struct packed {
    logic        prog;
    logic        page_erase;
    logic        mass_erase;
    logic        info;
    logic [15:0] addr;
    logic [7:0]  data;
  } fcu_flash_type;

endpackage : fcu_pkg

//--- fcu_op_timer.sv
`timescale 1ns/1ps
`default_nettype none
module fcu_op_timer (
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  input  wire logic                         start,
  input  wire logic [fcu_pkg::FCU_TMR_W-1:0] cycles,
  output logic                              done_q
);
  import fcu_pkg::*;

  logic [FCU_TMR_W-1:0] count_q;
  logic                 run_q;
  wire                  last = run_q && (count_q <= {{(FCU_TMR_W-1){1'b0}}, 1'b1});

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_q <= '0;
      run_q   <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      done_q <= last;
      if (start) begin
        count_q <= cycles;
        run_q   <= 1'b1;
      end else if (last) begin
        run_q <= 1'b0;
      end else if (run_q) begin
        count_q <= count_q - 1'b1;
      end
    end
  end

endmodule : fcu_op_timer
`default_nettype wire

//--- fcu_ctrl.sv
// Notes on behaviour
// - Debug-port operations ignore the write-protect option bit.
// - Debug-port operations ignore set sector guard bits.
// - Debug-port program writes accepted at any address.
// - Debug-port writes may set and clear sector guard bits.
// - Debug unlock completes after 73h, 8Ch without page rewrite.
// - Debug page writes while unlocked keep the controller unlocked.
// - Command 63h erases whole array, debug only; status 10_0000.
// - Debug page erase and program refused when read-protect is on.
// - One address: writes hit command register, reads return status.
// - 73h then 8Ch unlock, status 01, 02, then 03 when unlocked.
// - 95h while unlocked erases selected page; status 01_0000.
// - Undefined or out-of-order command codes lock the controller when not busy.
// - Status always readable, top bits zero, 00 locked, 04 guard selected.
// - Byte program in progress reports status 00_1000.
// - Page field forms program address bits 15 to 9.
// - Page erase sets all bytes whose top 7 address bits match to FFh.
// - Info select bit maps information area at FE00h to FFFFh.
// - Guard selected hides page register at the shared address.
// - Guard register exposed only after command 5Eh.
// - User writes only set guard bits; zeros leave them unchanged.
// - Guard bit blocks user program and erase of its sector; reset zero.
// - Page erase completion returns the controller to locked.
// - User program writes outside the unlocked page are ignored.
// - Any command write other than 5Eh deselects the guard register.
`timescale 1ns/1ps
`default_nettype none
module fcu_ctrl #(
  parameter int PROG_CYCLES   = fcu_pkg::FCU_PROG_CYC,
  parameter int PERASE_CYCLES = fcu_pkg::FCU_PERASE_CYC,
  parameter int MERASE_CYCLES = fcu_pkg::FCU_MERASE_CYC
) (
  input  wire logic                       ref_clk,
  input  wire logic                       rst,
  input  wire logic [13:0]                avs_address,
  input  wire logic                       avs_read,
  input  wire logic                       avs_write,
  input  wire logic [31:0]                avs_writedata,
  input  wire logic [3:0]                 avs_byteenable,
  input  wire logic                       avs_debug,
  output logic [31:0]                     avs_readdata,
  output logic                            avs_waitrequest,
  input  wire logic                       prog_valid,
  input  wire fcu_pkg::fcu_prog_req_type  prog_req,
  output logic                            prog_ready,
  output fcu_pkg::fcu_flash_type          flash_ctl,
  output logic [5:0]                      flash_state_out
);
  import fcu_pkg::*;

  fcu_state_type    state_q, state_d;
  logic [7:0]       page_q, page_d;
  logic [7:0]       guard_q, guard_d;
  logic [1:0]       opt_q, opt_d;
  logic [31:0]      rdata_q;
  logic             wait_q;
  logic             ready_q;
  fcu_flash_type    flash_q, flash_d;
  logic [5:0]       status_q;
  logic             start_op;
  logic [FCU_TMR_W-1:0] op_cycles;
  logic             op_done;

  // Bus decode; one wait cycle, then the access completes
  wire req        = avs_read || avs_write;
  wire accept     = req && !wait_q;
  wire lane0      = avs_byteenable[0];
  wire hit_cmd    = avs_address == FCU_CMD_ADDR;
  wire hit_page   = avs_address == FCU_PAGE_ADDR;
  wire hit_opt    = avs_address == FCU_OPT_ADDR;
  wire [7:0] wbyte = avs_writedata[7:0];
  wire cmd_wr     = accept && avs_write && lane0 && hit_cmd;
  wire page_wr    = accept && avs_write && lane0 && hit_page;
  wire opt_wr     = accept && avs_write && lane0 && hit_opt;
  wire dbg        = avs_debug;
  wire busy       = state_q == FCU_PROG || state_q == FCU_PERASE
                 || state_q == FCU_MERASE;

  // Options and protection
  wire wp_opt     = opt_q[FCU_OPT_WP_BIT];
  wire rp_opt     = opt_q[FCU_OPT_RP_BIT];
  wire [2:0] erase_sect = page_q[FCU_SECT_LSB +: 3];
  wire erase_guarded = guard_q[erase_sect];
  wire perase_ok  = dbg ? !rp_opt : (!wp_opt && !erase_guarded);

  // Program request checks
  wire [6:0] req_page  = prog_req.addr[FCU_PAGE_LSB +: FCU_PAGE_W];
  wire [2:0] req_sect  = req_page[FCU_SECT_LSB +: 3];
  wire info_sel        = page_q[FCU_INFO_BIT];
  wire info_hit        = info_sel && (req_page == FCU_INFO_PAGE);
  wire page_match      = req_page == page_q[FCU_PAGE_W-1:0];
  wire prog_in_page    = prog_req.debug || page_match;
  wire prog_guard_ok   = prog_req.debug ? !rp_opt
                       : (!wp_opt && !guard_q[req_sect]);
  wire prog_take       = prog_valid && ready_q;
  wire prog_go         = prog_take && state_q == FCU_UNLOCKED
                       && prog_in_page && prog_guard_ok;

  // Next state
  always_comb begin
    state_d = state_q;
    if (busy) begin
      if (op_done) begin
        state_d = (state_q == FCU_PROG) ? FCU_UNLOCKED : FCU_LOCKED;
      end
    end else if (cmd_wr) begin
      state_d = FCU_LOCKED;
      unique case (wbyte)
        FCU_CMD_UNLOCK1: begin
          if (state_q == FCU_LOCKED) begin
            state_d = FCU_UNLK1;
          end
        end
        FCU_CMD_UNLOCK2: begin
          if (state_q == FCU_UNLK1) begin
            state_d = dbg ? FCU_UNLOCKED : FCU_UNLK2;
          end
        end
        FCU_CMD_PERASE: begin
          if (state_q == FCU_UNLOCKED && perase_ok) begin
            state_d = FCU_PERASE;
          end
        end
        FCU_CMD_MERASE: begin
          if (state_q == FCU_UNLOCKED && dbg) begin
            state_d = FCU_MERASE;
          end
        end
        FCU_CMD_GUARD: begin
          state_d = FCU_GUARD;
        end
        default: begin
          state_d = FCU_LOCKED;
        end
      endcase
    end else if (page_wr) begin
      unique case (state_q)
        FCU_UNLK1: begin
          state_d = FCU_LOCKED;
        end
        FCU_UNLK2: begin
          state_d = (wbyte == page_q) ? FCU_UNLOCKED : FCU_LOCKED;
        end
        FCU_UNLOCKED: begin
          state_d = dbg ? FCU_UNLOCKED : FCU_LOCKED;
        end
        default: begin
          state_d = state_q;
        end
      endcase
    end else if (prog_go) begin
      state_d = FCU_PROG;
    end
  end

  // Page and guard registers share one address
  always_comb begin
    page_d  = page_q;
    guard_d = guard_q;
    if (page_wr && !busy) begin
      if (state_q == FCU_GUARD) begin
        guard_d = dbg ? wbyte : (guard_q | wbyte);
      end else if (state_q == FCU_LOCKED
                || (state_q == FCU_UNLOCKED && dbg)) begin
        page_d = wbyte;
      end
    end
  end

  always_comb begin
    opt_d = opt_q;
    if (opt_wr) begin
      opt_d = wbyte[1:0];
    end
  end

  // Operation start and flash macro controls
  assign start_op = (state_d != state_q)
                 && (state_d == FCU_PROG || state_d == FCU_PERASE
                  || state_d == FCU_MERASE);

  always_comb begin
    op_cycles = FCU_TMR_W'(PROG_CYCLES);
    if (state_d == FCU_PERASE) begin
      op_cycles = FCU_TMR_W'(PERASE_CYCLES);
    end else if (state_d == FCU_MERASE) begin
      op_cycles = FCU_TMR_W'(MERASE_CYCLES);
    end
  end

  always_comb begin
    flash_d      = flash_q;
    flash_d.prog = 1'b0;
    if (start_op && state_d == FCU_PROG) begin
      flash_d.prog = 1'b1;
      flash_d.addr = prog_req.addr;
      flash_d.data = prog_req.data;
      flash_d.info = info_hit;
    end
    if (start_op && state_d == FCU_PERASE) begin
      // Every byte whose top address bits equal the page reads FFh after
      flash_d.addr = {page_q[FCU_PAGE_W-1:0], 9'h000};
      flash_d.info = info_sel && page_q[FCU_PAGE_W-1:0] == FCU_INFO_PAGE;
      flash_d.data = 8'hFF;
    end
    flash_d.page_erase = (state_d == FCU_PERASE);
    flash_d.mass_erase = (state_d == FCU_MERASE);
  end

  // Status encoding; low bits of busy codes stay zero
  logic [5:0] status_d;
  always_comb begin
    unique case (state_d)
      FCU_LOCKED:   status_d = FCU_ST_LOCKED;
      FCU_UNLK1:    status_d = FCU_ST_UNLK1;
      FCU_UNLK2:    status_d = FCU_ST_UNLK2;
      FCU_UNLOCKED: status_d = FCU_ST_UNLOCKED;
      FCU_GUARD:    status_d = FCU_ST_GUARD;
      FCU_PROG:     status_d = FCU_ST_PROG;
      FCU_PERASE:   status_d = FCU_ST_PERASE;
      FCU_MERASE:   status_d = FCU_ST_MERASE;
    endcase
  end

  // Read mux; page register hidden while the guard is selected
  wire [7:0] page_view = (state_q == FCU_GUARD) ? guard_q : page_q;
  wire [7:0] rd_byte   = hit_cmd  ? {2'b00, status_q} :
                         hit_page ? page_view :
                         hit_opt  ? {6'h00, opt_q} : 8'h00;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      state_q  <= FCU_LOCKED;
      page_q   <= FCU_PAGE_RST;
      guard_q  <= FCU_GUARD_RST;
      opt_q    <= FCU_OPT_RST;
      status_q <= FCU_ST_LOCKED;
      flash_q  <= '0;
    end else begin
      state_q  <= state_d;
      page_q   <= page_d;
      guard_q  <= guard_d;
      opt_q    <= opt_d;
      status_q <= status_d;
      flash_q  <= flash_d;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
      ready_q <= 1'b0;
    end else begin
      wait_q  <= !(req && wait_q);
      ready_q <= !(state_d == FCU_PROG || state_d == FCU_PERASE
                || state_d == FCU_MERASE) && !start_op && !prog_take;
      if (req && wait_q) begin
        rdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  fcu_op_timer fcu_op_timer_i (
    .ref_clk (ref_clk),
    .rst     (rst),
    .start   (start_op),
    .cycles  (op_cycles),
    .done_q  (op_done)
  );

  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign prog_ready      = ready_q;
  assign flash_ctl       = flash_q;
  assign flash_state_out = status_q;

endmodule : fcu_ctrl
`default_nettype wire

//--- fcu_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module fcu_ctrl_assertions (
  input wire logic                   ref_clk,
  input wire logic                   rst,
  input wire logic [13:0]            avs_address,
  input wire logic                   avs_read,
  input wire logic                   avs_write,
  input wire logic [31:0]            avs_writedata,
  input wire logic [3:0]             avs_byteenable,
  input wire logic                   avs_debug,
  input wire logic [31:0]            avs_readdata,
  input wire logic                   avs_waitrequest,
  input wire fcu_pkg::fcu_flash_type flash_ctl,
  input wire logic [5:0]             flash_state_out
);
  import fcu_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire       cmd_wr = avs_write && !avs_waitrequest && avs_byteenable[0]
                      && avs_address == FCU_CMD_ADDR;
  wire [7:0] wd     = avs_writedata[7:0];
  wire       st_idle = flash_state_out[5:3] == 3'h0;
  wire       known  = wd inside {FCU_CMD_UNLOCK1, FCU_CMD_UNLOCK2, FCU_CMD_PERASE,
                                 FCU_CMD_MERASE, FCU_CMD_GUARD};
  property p_wait_ans;
    (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
  endproperty
  a_wait_ans: assert property (p_wait_ans) else $error("access not answered");
  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer too long");
  property p_rd_st;
    avs_read && avs_waitrequest && avs_address == FCU_CMD_ADDR
      |=> avs_readdata == {26'h0, $past(flash_state_out)};
  endproperty
  a_rd_st: assert property (p_rd_st) else $error("status read wrong");
  property p_codes;
    flash_state_out inside {6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h08, 6'h10, 6'h20};
  endproperty
  a_codes: assert property (p_codes) else $error("illegal status code");
  property p_prog;
    flash_ctl.prog |-> flash_state_out == FCU_ST_PROG ##1 !flash_ctl.prog;
  endproperty
  a_prog: assert property (p_prog) else $error("program pulse wrong");
  property p_pe;
    flash_ctl.page_erase |-> flash_state_out == FCU_ST_PERASE && flash_ctl.data == 8'hFF
      && flash_ctl.addr[8:0] == 9'h000;
  endproperty
  a_pe: assert property (p_pe) else $error("page erase target wrong");
  property p_pe_end;
    $fell(flash_state_out == FCU_ST_PERASE) |-> flash_state_out == FCU_ST_LOCKED;
  endproperty
  a_pe_end: assert property (p_pe_end) else $error("not locked after erase");
  property p_me_dbg;
    $rose(flash_state_out == FCU_ST_MERASE) |-> $past(avs_write && avs_debug);
  endproperty
  a_me_dbg: assert property (p_me_dbg) else $error("mass erase without debug");
  property p_bad;
    cmd_wr && st_idle && !known |=> flash_state_out == FCU_ST_LOCKED;
  endproperty
  a_bad: assert property (p_bad) else $error("undefined code kept unlock");
  property p_guard;
    cmd_wr && st_idle && wd == FCU_CMD_GUARD |=> flash_state_out == FCU_ST_GUARD;
  endproperty
  a_guard: assert property (p_guard) else $error("guard not selected");
  c_prog: cover property (flash_ctl.prog);
  c_pe: cover property (flash_ctl.page_erase);
  c_me: cover property (flash_ctl.mass_erase);
endmodule : fcu_ctrl_assertions
bind fcu_ctrl fcu_ctrl_assertions fcu_ctrl_assertions_i (.ref_clk, .rst, .avs_address,
  .avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_debug, .avs_readdata,
  .avs_waitrequest, .flash_ctl, .flash_state_out);
`default_nettype wire

//--- fcu_prog_src.sv
`timescale 1ns/1ps
`default_nettype none
module fcu_prog_src (
  input  wire logic                  ref_clk,
  input  wire logic                  prog_ready,
  output var logic                   prog_valid,
  output var fcu_pkg::fcu_prog_req_type prog_req
);
  import fcu_pkg::*;
  initial begin
    prog_valid = 1'b0;
    prog_req = '0;
  end
  // One byte per request; the origin flag rides with it
  task automatic put(input logic [15:0] a, input logic [7:0] d, input logic dbg);
    @(posedge ref_clk);
    prog_valid <= 1'b1;
    prog_req <= '{a, d, dbg};
    do @(posedge ref_clk); while (prog_ready !== 1'b1);
    prog_valid <= 1'b0;
    prog_req <= ~prog_req;
  endtask : put
endmodule : fcu_prog_src
`default_nettype wire

//--- fcu_ctrl_bench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: %h expected %h", $time, (a), (e)); end end
module fcu_ctrl_bench;
  import fcu_pkg::*;
  logic             ref_clk, rst, avs_read, avs_write, avs_debug, avs_waitrequest;
  logic             prog_valid, prog_ready;
  logic [13:0]      avs_address;
  logic [31:0]      avs_writedata, avs_readdata, rd_q;
  logic [5:0]       flash_state_out;
  fcu_prog_req_type prog_req;
  fcu_flash_type    flash_ctl, last_q;
  int               error_cnt = 0, num_checks = 0, prog_cnt = 0, pe_cnt = 0, me_cnt = 0;
  fcu_ctrl #(.PROG_CYCLES(5), .PERASE_CYCLES(8), .MERASE_CYCLES(10)) fcu_ctrl_i (
    .ref_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_debug, .avs_readdata, .avs_waitrequest,
    .prog_valid, .prog_req, .prog_ready, .flash_ctl, .flash_state_out);
  fcu_prog_src fcu_prog_src_i (.ref_clk, .prog_ready, .prog_valid, .prog_req);
  always @(posedge ref_clk) begin
    if (flash_ctl.prog === 1'b1) begin
      prog_cnt++;
      last_q <= flash_ctl;
    end
    if ($rose(flash_ctl.page_erase)) begin
      pe_cnt++;
      last_q <= flash_ctl;
    end
    if ($rose(flash_ctl.mass_erase)) me_cnt++;
  end
  task automatic acc(input logic w, input logic [13:0] a, input logic [7:0] d, input logic g);
    @(posedge ref_clk);
    avs_write <= w;
    avs_read <= !w;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_debug <= g;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd_q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : acc
  task automatic cmd(input logic [7:0] c, input logic g);
    acc(1'b1, FCU_CMD_ADDR, c, g);
  endtask : cmd
  task automatic pg(input logic [7:0] p, input logic g);
    acc(1'b1, FCU_PAGE_ADDR, p, g);
  endtask : pg
  task automatic rc(input logic [13:0] a, input logic [7:0] e);
    acc(1'b0, a, 8'h00, 1'b0);
    `CHK(rd_q, {24'h0, e})
  endtask : rc
  task automatic st(input logic [5:0] e);
    rc(FCU_CMD_ADDR, {2'b00, e});
  endtask : st
  task automatic unl(input logic [7:0] p, input logic g);
    cmd(8'h00, g);
    pg(p, g);
    cmd(FCU_CMD_UNLOCK1, g);
    cmd(FCU_CMD_UNLOCK2, g);
    if (!g) pg(p, 1'b0);
  endtask : unl
  task automatic idle();
    int n;
    n = 0;
    do begin
      acc(1'b0, FCU_CMD_ADDR, 8'h00, 1'b0);
      n++;
    end while (rd_q[5:3] != 3'h0 && n < 50);
    // A busy code that never clears is a failure, not a silent pass
    if (rd_q[5:3] !== 3'h0) error_cnt++;
  endtask : idle
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : summarize
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  initial begin
    #100000;
    error_cnt++;
    summarize();
  end
  initial begin
    rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    avs_debug = 1'b0;
    repeat (16) @(posedge ref_clk);
    rst <= 1'b0;
    st(FCU_ST_LOCKED);
    rc(FCU_PAGE_ADDR, 8'h00);
    cmd(FCU_CMD_GUARD, 1'b0);
    st(FCU_ST_GUARD);
    rc(FCU_PAGE_ADDR, 8'h00);
    pg(8'h05, 1'b0);
    pg(8'h00, 1'b0);
    rc(FCU_PAGE_ADDR, 8'h05);
    pg(8'h00, 1'b1);
    rc(FCU_PAGE_ADDR, 8'h00);
    pg(8'h04, 1'b0);
    st(FCU_ST_GUARD);
    cmd(8'h00, 1'b0);
    st(FCU_ST_LOCKED);
    rc(FCU_PAGE_ADDR, 8'h00);
    rc(14'h0100, 8'h00);
    $display("test guard done");
    cmd(8'h00, 1'b0);
    pg(8'h10, 1'b0);
    cmd(FCU_CMD_UNLOCK1, 1'b0);
    st(FCU_ST_UNLK1);
    cmd(FCU_CMD_UNLOCK2, 1'b0);
    st(FCU_ST_UNLK2);
    pg(8'h10, 1'b0);
    st(FCU_ST_UNLOCKED);
    fcu_prog_src_i.put(16'h2010, 8'hA5, 1'b0);
    st(FCU_ST_PROG);
    idle();
    `CHK(last_q.addr, 16'h2010)
    `CHK(last_q.data, 8'hA5)
    st(FCU_ST_UNLOCKED);
    fcu_prog_src_i.put(16'h2210, 8'h11, 1'b0);
    st(FCU_ST_UNLOCKED);
    `CHK(prog_cnt, 1)
    fcu_prog_src_i.put(16'h4400, 8'h22, 1'b1);
    idle();
    `CHK(prog_cnt, 2)
    $display("test program done");
    unl(8'h08, 1'b0);
    fcu_prog_src_i.put(16'h1004, 8'h33, 1'b1);
    idle();
    `CHK(prog_cnt, 3)
    fcu_prog_src_i.put(16'h1008, 8'h44, 1'b0);
    idle();
    `CHK(prog_cnt, 3)
    cmd(FCU_CMD_PERASE, 1'b0);
    st(FCU_ST_LOCKED);
    unl(8'h10, 1'b0);
    cmd(FCU_CMD_PERASE, 1'b0);
    st(FCU_ST_PERASE);
    idle();
    st(FCU_ST_LOCKED);
    `CHK(pe_cnt, 1)
    `CHK(last_q.addr, 16'h2000)
    `CHK(last_q.data, 8'hFF)
    unl(8'h10, 1'b0);
    cmd(8'h42, 1'b0);
    st(FCU_ST_LOCKED);
    cmd(FCU_CMD_UNLOCK2, 1'b0);
    st(FCU_ST_LOCKED);
    $display("test erase done");
    unl(8'h10, 1'b1);
    st(FCU_ST_UNLOCKED);
    pg(8'h80, 1'b1);
    st(FCU_ST_UNLOCKED);
    cmd(FCU_CMD_MERASE, 1'b0);
    st(FCU_ST_LOCKED);
    unl(8'h10, 1'b1);
    cmd(FCU_CMD_MERASE, 1'b1);
    st(FCU_ST_MERASE);
    idle();
    `CHK(me_cnt, 1)
    acc(1'b1, FCU_OPT_ADDR, 8'h01, 1'b1);
    unl(8'h80, 1'b1);
    fcu_prog_src_i.put(16'hFE10, 8'h3C, 1'b1);
    idle();
    `CHK(prog_cnt, 4)
    `CHK(last_q.info, 1'b1)
    `CHK(last_q.addr, 16'hFE10)
    unl(8'h10, 1'b0);
    fcu_prog_src_i.put(16'h2030, 8'h66, 1'b0);
    idle();
    `CHK(prog_cnt, 4)
    acc(1'b1, FCU_OPT_ADDR, 8'h02, 1'b1);
    rc(FCU_OPT_ADDR, 8'h02);
    unl(8'h10, 1'b1);
    fcu_prog_src_i.put(16'h2020, 8'h55, 1'b1);
    cmd(FCU_CMD_PERASE, 1'b1);
    idle();
    `CHK(prog_cnt, 4)
    `CHK(pe_cnt, 1)
    $display("test debug done");
    summarize();
  end
endmodule : fcu_ctrl_bench
`default_nettype wire
